// ### src/tx_setup_pkg.sv
// Constants for the per-queue transmit setup registers
package tx_setup_pkg;
  // Register offsets within one queue window
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_SIZE = 5'h04;
  localparam logic [4:0] OFF_SETUP = 5'h08;
  localparam logic [4:0] OFF_DATA = 5'h0c;
  // Packet control word fields
  localparam int PRELOAD_LSB = 25;
  localparam int PRELOAD_W = 5;
  localparam int TAG_LSB = 16;
  localparam int TAG_W = 9;
  localparam int IPOFF_LSB = 10;
  localparam int IPOFF_W = 6;
  localparam int APPEND_CRC_BIT = 9;
  localparam int FIX_CRC_BIT = 8;
  localparam int NO_PAD_BIT = 6;
  localparam int LATE_BIT = 5;
  localparam int EARLY_BIT = 4;
  localparam int COLL_BIT = 3;
  localparam int NO_DEFER_BIT = 2;
  localparam int FAST_BO_BIT = 1;
  // Packet size and write setup fields
  localparam int SIZE_W = 16;
  localparam int ENDIAN_BIT = 24;
  localparam int START_LSB = 18;
  localparam int END_LSB = 16;
  localparam int OFFSET_W = 2;
  localparam int COUNT_W = 14;
  localparam int LANES = 4;
  localparam logic [2:0] BYTES_PER_WORD = 3'h4;
  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [15:0] SIZE_RESET = 16'h0000;
  localparam logic [1:0] OFFSET_RESET = 2'h0;
  localparam logic [13:0] COUNT_RESET = 14'h0000;
endpackage

// ### src/byte_lane_mask.sv
// Byte lane enables that skip a number of lanes from one end of a word
`timescale 1ns/1ps
`default_nettype none
module byte_lane_mask #(
  parameter int LANES = 4
) (
  // Skip request
  input wire logic [2:0] skip_in,
  input wire logic from_low_in,
  // Lane enables
  output logic [LANES-1:0] lane_en_out
);
  // One compare per lane
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_en_out[i] = from_low_in ? (3'(i) >= skip_in)
                                        : ((4'(i) + {1'b0, skip_in}) < 4'(LANES));
  end
endmodule
`default_nettype wire

// ### src/write_counter.sv
// Loadable down-counter that holds at zero
`timescale 1ns/1ps
`default_nettype none
module write_counter #(
  parameter int W = 14
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic dec_in,
  // State
  output logic [W-1:0] count_out,
  output logic zero_out
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // Host load wins, else step down to zero
  always_comb begin
    count_d = count_q;
    if (load_in) begin
      count_d = load_val_in;
    end else if (dec_in && count_q != '0) begin
      count_d = count_q - W'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
  assign zero_out = (count_q == '0);
endmodule
`default_nettype wire

// ### src/tx_queue_write_setup.sv
// Per-queue transmit setup registers and masked queue write path
//
// Behaviour
// - Control word preload field sets bytes held in MAC FIFO before transmit.
// - Control word holds a 9-bit packet tag reported in transmit status.
// - Nonzero IP header offset requests IP header checksum correction.
// - Append-CRC bit makes the transmitter add a correct CRC.
// - Fix-CRC bit makes the transmitter overwrite the existing CRC.
// - Disable-padding bit stops padding of frames shorter than 64 bytes.
// - Late-notify bit requests an interrupt on transmit completion.
// - Early-notify bit requests an interrupt at start of transmission.
// - Bit 3 requests an interrupt on excessive collisions.
// - Bit 1 selects fast back-off; bit 2 disables deferral timeout.
// - Packet size register is a 16-bit read-write byte count.
// - Byte-order bit set sends most significant byte first, clear least.
// - Start offset masks writes while count nonzero, then clears itself.
// - End offset masks writes while count zero and never self-clears.
// - Remaining size below four replaces the end offset as mask.
// - 14-bit write count decrements per queue write, holds at zero.
// - Each data word is appended to this queue after byte masking.
`timescale 1ns/1ps
`default_nettype none
module tx_queue_write_setup #(
  parameter int COUNT_W = tx_setup_pkg::COUNT_W,
  parameter int SIZE_W = tx_setup_pkg::SIZE_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Host register port for this queue window
  input wire logic host_cs_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [4:0] host_addr_in,
  input wire logic [31:0] host_wdata_in,
  output logic [31:0] host_rdata_out,
  // Masked words appended to the queue
  output logic queue_valid_out,
  output logic [31:0] queue_data_out,
  output logic [3:0] queue_byte_en_out,
  // Packet settings toward the transmitter
  output logic [4:0] preload_out,
  output logic [8:0] packet_tag_out,
  output logic [5:0] ip_header_offset_out,
  output logic ip_checksum_fix_out,
  output logic append_crc_out,
  output logic fix_crc_out,
  output logic disable_padding_out,
  output logic late_notify_out,
  output logic early_notify_out,
  output logic collision_notify_out,
  output logic no_defer_timeout_out,
  output logic fast_backoff_out,
  output logic big_endian_out,
  output logic [SIZE_W-1:0] packet_size_out,
  output logic [COUNT_W-1:0] write_count_out
);
  logic ctl_wr;
  logic size_wr;
  logic setup_wr;
  logic data_wr;
  logic host_rd;
  logic [31:0] control_q;
  logic [31:0] control_d;
  logic [SIZE_W-1:0] size_q;
  logic [SIZE_W-1:0] size_d;
  logic [SIZE_W-1:0] remaining_q;
  logic [SIZE_W-1:0] remaining_d;
  logic big_q;
  logic big_d;
  logic [1:0] start_q;
  logic [1:0] start_d;
  logic [1:0] end_q;
  logic [1:0] end_d;
  logic q_valid_q;
  logic q_valid_d;
  logic [31:0] q_data_q;
  logic [31:0] q_data_d;
  logic [3:0] q_en_q;
  logic [3:0] q_en_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [COUNT_W-1:0] count;
  logic count_zero;
  logic use_start;
  logic short_tail;
  logic [2:0] skip;
  logic from_low;
  logic [3:0] lane_en;
  logic [2:0] kept;

  // Strobe decode
  // Own window only
  assign ctl_wr = host_cs_in && host_wr_in && host_addr_in == tx_setup_pkg::OFF_CONTROL;
  assign size_wr = host_cs_in && host_wr_in && host_addr_in == tx_setup_pkg::OFF_SIZE;
  assign setup_wr = host_cs_in && host_wr_in && host_addr_in == tx_setup_pkg::OFF_SETUP;
  assign data_wr = host_cs_in && host_wr_in && host_addr_in == tx_setup_pkg::OFF_DATA;
  assign host_rd = host_cs_in && host_rd_in;

  write_counter #(
    .W(COUNT_W)
  ) u_count (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .load_in(setup_wr),
    .load_val_in(host_wdata_in[COUNT_W-1:0]),
    .dec_in(data_wr),
    .count_out(count),
    .zero_out(count_zero)
  );

  assign use_start = !count_zero;
  assign short_tail = remaining_q < SIZE_W'(tx_setup_pkg::BYTES_PER_WORD);

  // Start mask while count nonzero, end mask or remainder while count zero
  always_comb begin
    if (use_start) begin
      skip = {1'b0, start_q};
    end else if (short_tail) begin
      skip = tx_setup_pkg::BYTES_PER_WORD - remaining_q[2:0];
    end else begin
      skip = {1'b0, end_q};
    end
  end

  assign from_low = use_start ? !big_q : big_q;

  byte_lane_mask #(
    .LANES(tx_setup_pkg::LANES)
  ) u_mask (
    .skip_in(skip),
    .from_low_in(from_low),
    .lane_en_out(lane_en)
  );

  assign kept = {2'b00, lane_en[0]} + {2'b00, lane_en[1]}
              + {2'b00, lane_en[2]} + {2'b00, lane_en[3]};

  // Register next values
  always_comb begin
    control_d = control_q;
    size_d = size_q;
    big_d = big_q;
    start_d = start_q;
    end_d = end_q;
    remaining_d = remaining_q;
    if (ctl_wr) begin
      control_d = host_wdata_in;
    end
    if (size_wr) begin
      size_d = host_wdata_in[SIZE_W-1:0];
    end
    if (setup_wr) begin
      big_d = host_wdata_in[tx_setup_pkg::ENDIAN_BIT];
      start_d = host_wdata_in[tx_setup_pkg::START_LSB +: tx_setup_pkg::OFFSET_W];
      end_d = host_wdata_in[tx_setup_pkg::END_LSB +: tx_setup_pkg::OFFSET_W];
      remaining_d = size_q;
    end else if (data_wr) begin
      if (use_start) begin
        start_d = tx_setup_pkg::OFFSET_RESET;
      end
      remaining_d = (remaining_q > SIZE_W'(kept)) ? remaining_q - SIZE_W'(kept) : '0;
    end
  end

  always_comb begin
    q_valid_d = data_wr;
    q_data_d = q_data_q;
    q_en_d = q_en_q;
    if (data_wr) begin
      q_data_d = host_wdata_in;
      q_en_d = lane_en;
    end
  end

  // Read data
  always_comb begin
    rdata_d = rdata_q;
    if (host_rd) begin
      unique case (host_addr_in)
        tx_setup_pkg::OFF_SIZE: rdata_d = {16'h0000, size_q};
        tx_setup_pkg::OFF_SETUP: rdata_d = {7'h00, big_q, 4'h0, start_q, end_q,
                                            2'h0, count};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      control_q <= tx_setup_pkg::CONTROL_RESET;
      size_q <= tx_setup_pkg::SIZE_RESET;
      remaining_q <= tx_setup_pkg::SIZE_RESET;
      big_q <= 1'b0;
      start_q <= tx_setup_pkg::OFFSET_RESET;
      end_q <= tx_setup_pkg::OFFSET_RESET;
      q_valid_q <= 1'b0;
      q_data_q <= 32'h0000_0000;
      q_en_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      control_q <= control_d;
      size_q <= size_d;
      remaining_q <= remaining_d;
      big_q <= big_d;
      start_q <= start_d;
      end_q <= end_d;
      q_valid_q <= q_valid_d;
      q_data_q <= q_data_d;
      q_en_q <= q_en_d;
      rdata_q <= rdata_d;
    end
  end

  assign preload_out = control_q[tx_setup_pkg::PRELOAD_LSB +: tx_setup_pkg::PRELOAD_W];
  assign packet_tag_out = control_q[tx_setup_pkg::TAG_LSB +: tx_setup_pkg::TAG_W];
  assign ip_header_offset_out = control_q[tx_setup_pkg::IPOFF_LSB +: tx_setup_pkg::IPOFF_W];
  assign ip_checksum_fix_out = ip_header_offset_out != 6'h00;
  assign append_crc_out = control_q[tx_setup_pkg::APPEND_CRC_BIT];
  assign fix_crc_out = control_q[tx_setup_pkg::FIX_CRC_BIT];
  assign disable_padding_out = control_q[tx_setup_pkg::NO_PAD_BIT];
  assign late_notify_out = control_q[tx_setup_pkg::LATE_BIT];
  assign early_notify_out = control_q[tx_setup_pkg::EARLY_BIT];
  assign collision_notify_out = control_q[tx_setup_pkg::COLL_BIT];
  assign no_defer_timeout_out = control_q[tx_setup_pkg::NO_DEFER_BIT];
  assign fast_backoff_out = control_q[tx_setup_pkg::FAST_BO_BIT];
  assign big_endian_out = big_q;
  assign packet_size_out = size_q;
  assign write_count_out = count;
  assign queue_valid_out = q_valid_q;
  assign queue_data_out = q_data_q;
  assign queue_byte_en_out = q_en_q;
  assign host_rdata_out = rdata_q;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_size_wr;
    size_wr;
  endsequence
  sequence s_size_rd;
    host_rd && host_addr_in == tx_setup_pkg::OFF_SIZE && !size_wr;
  endsequence

  property p_preload;
    ctl_wr |=> preload_out == $past(host_wdata_in[29:25]);
  endproperty
  a_preload: assert property (p_preload) else $error("preload not taken");

  property p_tag;
    ctl_wr |=> packet_tag_out == $past(host_wdata_in[24:16]);
  endproperty
  a_tag: assert property (p_tag) else $error("packet tag not taken");

  property p_ipfix;
    ctl_wr |=> ip_checksum_fix_out == ($past(host_wdata_in[15:10]) != 6'h00);
  endproperty
  a_ipfix: assert property (p_ipfix) else $error("checksum fix wrong");

  property p_crc;
    ctl_wr |=> {append_crc_out, fix_crc_out, disable_padding_out}
               == {$past(host_wdata_in[9:8]), $past(host_wdata_in[6])};
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag wrong");

  property p_irq;
    ctl_wr |=> {late_notify_out, early_notify_out, collision_notify_out, no_defer_timeout_out,
                fast_backoff_out} == $past(host_wdata_in[5:1]);
  endproperty
  a_irq: assert property (p_irq) else $error("notify flag wrong");

  property p_size;
    s_size_wr ##1 s_size_rd |=> host_rdata_out == {16'h0000, $past(host_wdata_in[15:0], 2)};
  endproperty
  a_size: assert property (p_size) else $error("size readback wrong");

  property p_order;
    data_wr && use_start && start_q == 2'h1 |=>
      queue_byte_en_out == ($past(big_q) ? 4'h7 : 4'he);
  endproperty
  a_order: assert property (p_order) else $error("start lanes wrong");

  property p_start_clear;
    data_wr && use_start |=> start_q == 2'h0;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start offset kept");

  property p_end_hold;
    data_wr && count_zero |=> end_q == $past(end_q) && count_zero;
  endproperty
  a_end_hold: assert property (p_end_hold) else $error("end offset changed");

  property p_short;
    data_wr && count_zero && short_tail |=>
      $countones(queue_byte_en_out) == int'($past(remaining_q[2:0]));
  endproperty
  a_short: assert property (p_short) else $error("short tail mask wrong");

  property p_count;
    data_wr && !count_zero |=> count == $past(count) - 14'h0001;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");

  property p_append;
    data_wr |=> queue_valid_out && queue_data_out == $past(host_wdata_in);
  endproperty
  a_append: assert property (p_append) else $error("word not appended");

  property p_other;
    !data_wr && !setup_wr |=> count == $past(count) && start_q == $past(start_q);
  endproperty
  a_other: assert property (p_other) else $error("setup moved without write");
endmodule
`default_nettype wire

// ### test/host_bus_model.sv
// Host processor model driving one queue register window
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic ref_clk_in,
  // Register bus
  output logic host_cs_out,
  output logic host_wr_out,
  output logic host_rd_out,
  output logic [4:0] host_addr_out,
  output logic [31:0] host_wdata_out,
  input wire logic [31:0] host_rdata_in
);
  initial begin
    host_cs_out = 1'b0;
    host_wr_out = 1'b0;
    host_rd_out = 1'b0;
    host_addr_out = 5'h00;
    host_wdata_out = 32'h0000_0000;
  end
  // One access, driven after a falling edge and held through the taking edge
  task automatic acc(input logic cs, input logic wr, input logic [4:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    @(negedge ref_clk_in);
    host_cs_out = cs;
    host_wr_out = wr;
    host_rd_out = ~wr;
    host_addr_out = addr;
    host_wdata_out = wdata;
    @(posedge ref_clk_in);
    #1;
    rdata = host_rdata_in;
  endtask
  // Release the bus; data lines stop showing the last value
  task automatic idle();
    @(negedge ref_clk_in);
    host_cs_out = 1'b0;
    host_wr_out = 1'b0;
    host_rd_out = 1'b0;
    host_wdata_out = ~host_wdata_out;
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the queue transmit setup block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic host_cs, host_wr, host_rd, valid, ip_fix, big_endian;
  logic append_crc, fix_crc, no_pad, late, early, coll, no_defer, fast_bo;
  logic [4:0] host_addr, preload;
  logic [8:0] tag;
  logic [5:0] ip_off;
  logic [3:0] byte_en;
  logic [15:0] size;
  logic [13:0] count;
  logic [31:0] host_wdata, host_rdata, queue_data, rd_val, ctl_vec;
  int miscompares = 0;
  int cmp_count = 0;
  assign ctl_vec = {2'h0, preload, tag, ip_off, append_crc, fix_crc, 1'b0, no_pad,
                    late, early, coll, no_defer, fast_bo, 1'b0};
  always #5 ref_clk_in = ~ref_clk_in;
  host_bus_model host_bus_model_inst (.ref_clk_in(ref_clk_in), .host_cs_out(host_cs),
    .host_wr_out(host_wr), .host_rd_out(host_rd), .host_addr_out(host_addr),
    .host_wdata_out(host_wdata), .host_rdata_in(host_rdata));
  tx_queue_write_setup tx_queue_write_setup_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .host_cs_in(host_cs), .host_wr_in(host_wr), .host_rd_in(host_rd),
    .host_addr_in(host_addr), .host_wdata_in(host_wdata), .host_rdata_out(host_rdata),
    .queue_valid_out(valid), .queue_data_out(queue_data), .queue_byte_en_out(byte_en),
    .preload_out(preload), .packet_tag_out(tag), .ip_header_offset_out(ip_off),
    .ip_checksum_fix_out(ip_fix), .append_crc_out(append_crc), .fix_crc_out(fix_crc),
    .disable_padding_out(no_pad), .late_notify_out(late), .early_notify_out(early),
    .collision_notify_out(coll), .no_defer_timeout_out(no_defer),
    .fast_backoff_out(fast_bo), .big_endian_out(big_endian), .packet_size_out(size),
    .write_count_out(count));
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [4:0] addr, input logic [31:0] data);
    host_bus_model_inst.acc(1'b1, 1'b1, addr, data, rd_val);
  endtask
  task automatic rd(input logic [4:0] addr, input logic [31:0] exp);
    host_bus_model_inst.acc(1'b1, 1'b0, addr, 32'h0000_0000, rd_val);
    chk(rd_val, exp);
  endtask
  // Data write, then judge the appended word, its lanes and the count
  task automatic dw(input logic [31:0] w, input logic [3:0] en, input logic [13:0] cnt);
    wr(tx_setup_pkg::OFF_DATA, w);
    chk({11'h0, valid, byte_en, 2'h0, count}, {11'h0, 1'b1, en, 2'h0, cnt});
    chk(queue_data, w);
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
  endtask
  task automatic t_reset();
    rd(tx_setup_pkg::OFF_SIZE, 32'h0000_0000);
    rd(tx_setup_pkg::OFF_SETUP, 32'h0000_0000);
    rd(5'h10, 32'h0000_0000);
    chk(ctl_vec, 32'h0000_0000);
    chk({14'h0, big_endian, valid, size}, 32'h0000_0000);
  endtask
  task automatic t_control();
    logic [31:0] words [0:13];
    words = '{32'h0000_0200, 32'h0000_0100, 32'h0000_0040, 32'h0000_0020,
              32'h0000_0010, 32'h0000_0008, 32'h0000_0004, 32'h0000_0002,
              32'h3e00_0000, 32'h01ff_0000, 32'h0000_fc00, 32'h0000_0400,
              32'hffff_ffff, 32'h0000_03ff};
    for (int i = 0; i < 14; i++) begin
      wr(tx_setup_pkg::OFF_CONTROL, words[i]);
      chk(ctl_vec, words[i] & 32'h3fff_ff7e);
      chk({31'h0, ip_fix}, {31'h0, |words[i][15:10]});
    end
    rd(tx_setup_pkg::OFF_CONTROL, 32'h0000_0000);
  endtask
  // size register width, read straight after write
  task automatic t_size();
    wr(tx_setup_pkg::OFF_SIZE, 32'hffff_beef);
    chk({16'h0, size}, 32'h0000_beef);
    rd(tx_setup_pkg::OFF_SIZE, 32'h0000_beef);
    wr(5'h14, 32'h0000_1234);
    rd(5'h14, 32'h0000_0000);
    rd(tx_setup_pkg::OFF_SIZE, 32'h0000_beef);
  endtask
  task automatic t_little();
    wr(tx_setup_pkg::OFF_SIZE, 32'h0000_0006);
    wr(tx_setup_pkg::OFF_SETUP, 32'h0004_0001);
    rd(tx_setup_pkg::OFF_SETUP, 32'h0004_0001);
    dw(32'h1122_3344, 4'he, 14'h0000);
    dw(32'h5566_7788, 4'h7, 14'h0000);
    dw(32'h99aa_bbcc, 4'h0, 14'h0000);
    rd(tx_setup_pkg::OFF_SETUP, 32'h0000_0000);
  endtask
  task automatic t_big();
    wr(tx_setup_pkg::OFF_CONTROL, 32'h0200_0000);
    wr(tx_setup_pkg::OFF_SIZE, 32'h0000_0040);
    wr(tx_setup_pkg::OFF_SETUP, 32'h0109_0002);
    chk({31'h0, big_endian}, 32'h0000_0001);
    dw(32'ha1a2_a3a4, 4'h3, 14'h0001);
    dw(32'hb1b2_b3b4, 4'hf, 14'h0000);
    dw(32'hc1c2_c3c4, 4'he, 14'h0000);
    dw(32'hd1d2_d3d4, 4'he, 14'h0000);
    rd(tx_setup_pkg::OFF_SETUP, 32'h0101_0000);
    host_bus_model_inst.idle();
    @(posedge ref_clk_in);
    #1;
    chk({31'h0, valid}, 32'h0000_0000);
  endtask
  // writes outside this queue's data port, then a big endian short packet
  task automatic t_other();
    wr(tx_setup_pkg::OFF_SETUP, 32'h0000_0003);
    host_bus_model_inst.acc(1'b0, 1'b1, tx_setup_pkg::OFF_DATA, 32'h1234_5678, rd_val);
    chk({17'h0, valid, count}, 32'h0000_0003);
    wr(5'h10, 32'h1234_5678);
    chk({17'h0, valid, count}, 32'h0000_0003);
    rd(tx_setup_pkg::OFF_DATA, 32'h0000_0000);
    chk({17'h0, valid, count}, 32'h0000_0003);
    wr(tx_setup_pkg::OFF_SETUP, 32'h0001_0000);
    dw(32'h0f0e_0d0c, 4'h7, 14'h0000);
    wr(tx_setup_pkg::OFF_SIZE, 32'h0000_0005);
    wr(tx_setup_pkg::OFF_SETUP, 32'h0104_0001);
    dw(32'h2b2a_2928, 4'h7, 14'h0000);
    dw(32'h3b3a_3938, 4'hc, 14'h0000);
    host_bus_model_inst.idle();
  endtask
  initial begin
    #50000;
    miscompares++;
    test_done();
  end
  initial begin
    do_reset();
    t_reset();
    t_control();
    t_size();
    t_little();
    t_big();
    t_other();
    do_reset();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
